// [src/core_pkg.sv]
// Shared constants and types for the execute and decode block
package core_pkg;

   // -----------------------------------------------------------------
   // Spaces and reset values
   // -----------------------------------------------------------------
   localparam int         STACK_DEPTH = 6;
   localparam logic [7:0] SHORT_BASE  = 8'h80;
   localparam logic [11:0] PC_RESET   = 12'h000;
   localparam logic [7:0] ACC_RESET   = 8'h00;

   // -----------------------------------------------------------------
   // Instruction lengths in clock cycles
   // -----------------------------------------------------------------
   localparam logic [2:0] CYC_REL  = 3'd2;
   localparam logic [2:0] CYC_CTL  = 3'd2;
   localparam logic [2:0] CYC_STD  = 3'd4;
   localparam logic [2:0] CYC_BT   = 3'd5;

   // -----------------------------------------------------------------
   // Opcode fields
   // -----------------------------------------------------------------
   localparam logic [1:0] ALU_ADD  = 2'd0;
   localparam logic [1:0] ALU_AND  = 2'd1;
   localparam logic [1:0] ALU_CMP  = 2'd2;
   localparam logic [1:0] ALU_SUB  = 2'd3;
   localparam logic [1:0] UN_INC   = 2'd0;
   localparam logic [1:0] UN_DEC   = 2'd1;
   localparam logic [1:0] UN_CLR   = 2'd2;
   localparam logic [1:0] ACC_COM  = 2'd0;
   localparam logic [1:0] ACC_RLC  = 2'd1;
   localparam logic [1:0] ACC_SLA  = 2'd2;
   localparam logic [2:0] CTL_NOP  = 3'd0;
   localparam logic [2:0] CTL_RET  = 3'd1;
   localparam logic [2:0] CTL_RETURN_FROM_INTERRUPT = 3'd2;
   localparam logic [2:0] CTL_HALT = 3'd3;
   localparam logic [2:0] CTL_IDLE = 3'd4;
   localparam logic [1:0] COND_C   = 2'd0;
   localparam logic [1:0] COND_NC  = 2'd1;
   localparam logic [1:0] COND_Z   = 2'd2;
   localparam logic [1:0] COND_NZ  = 2'd3;

   typedef enum logic [3:0] {
      C_REL, C_JUMP, C_CALL, C_BTEST, C_BSET, C_ALU_IND, C_ALU_DIR, C_ALU_IMM,
      C_UN_IND, C_UN_DIR, C_SH_INC, C_SH_DEC, C_ACC, C_CTL
   } iclass_e;

endpackage

// [src/data_space.sv]
// 256-byte data space with registered read data
`timescale 1ns/1ns
module data_space (
   input  wire logic       clk,
   input  wire logic       rd_en,
   input  wire logic [7:0] rd_addr,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data
);
   typedef struct packed {
      logic [255:0][7:0] mem;
      logic [7:0]        rdata;
   } mem_s;

   mem_s mem_reg;
   mem_s mem_next;

   // Read returns the old byte on a same-cycle write
   always_comb begin
      mem_next = mem_reg;
      if (rd_en) begin
         mem_next.rdata = mem_reg.mem[rd_addr];
      end
      if (wr_en) begin
         mem_next.mem[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge clk) begin
      mem_reg <= mem_next;
   end

   assign rd_data = mem_reg.rdata;
endmodule

// [src/exec_core.sv]
// Decode and execute of arithmetic, branch, bit, control and jump groups
`timescale 1ns/1ns
module exec_core (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic [7:0]          prog_data,
   input  wire logic                wd_hw_select,
   input  wire logic                int_entry,
   output logic      [11:0]         prog_addr,
   output logic      [7:0]          acc_out,
   output logic                     zero_flag,
   output logic                     carry_flag,
   output logic                     halt_req,
   output logic                     idle_req,
   output logic                     instr_done
);
   import core_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]                    cnt;
      logic [11:0]                   pc;
      logic [11:0]                   pa;
      logic [7:0]                    op;
      logic [7:0]                    b1;
      logic [7:0]                    b2;
      logic [7:0]                    acc;
      logic                          z;
      logic                          c;
      logic                          sz;
      logic                          sc;
      logic [3:0][7:0]               xr;
      logic [STACK_DEPTH-1:0][11:0]  stk;
      logic [2:0]                    sp;
      logic                          wd1;
      logic                          wd2;
      logic                          halt;
      logic                          idle;
      logic                          done;
   } core_s;

   core_s       core_reg;
   core_s       core_next;
   logic        dm_re;
   logic [7:0]  dm_ra;
   logic        dm_we;
   logic [7:0]  dm_wa;
   logic [7:0]  dm_wd;
   logic [7:0]  dm_rd;
   iclass_e     cls;
   logic [8:0]  sum9;
   logic [8:0]  diff9;
   logic [7:0]  opd;
   logic [7:0]  un_opd;
   logic [7:0]  res;
   logic        cond_true;
   logic        tested_bit;
   logic [11:0] nxt;
   logic [11:0] ext_target;

   function automatic iclass_e decode(input logic [7:0] o);
      iclass_e r;
      r = C_CTL;
      if (!o[7]) r = C_REL;
      else if (o[6:4] == 3'b000) r = C_JUMP;
      else if (o[6:4] == 3'b001) r = C_CALL;
      else if (o[6:4] == 3'b010) r = C_BTEST;
      else if (o[6:4] == 3'b011) r = C_BSET;
      else if (o[6] && !o[5] && o[3:2] == 2'b00) r = C_ALU_IND;
      else if (o[6:2] == 5'b10001) r = C_ALU_DIR;
      else if (o[6:2] == 5'b10010) r = C_ALU_IMM;
      else if (o[6:5] == 2'b11 && o[3:2] == 2'b00 && o[1:0] != 2'b11) r = C_UN_IND;
      else if (o[6:2] == 5'b11001 && o[1:0] != 2'b11) r = C_UN_DIR;
      else if (o[6:2] == 5'b11010) r = C_SH_INC;
      else if (o[6:2] == 5'b11011) r = C_SH_DEC;
      else if (o[6:2] == 5'b10101 && o[1:0] != 2'b11) r = C_ACC;
      return r;
   endfunction

   function automatic logic [2:0] last_cycle(input iclass_e k);
      logic [2:0] n;
      unique case (k)
         C_REL:   n = CYC_REL;
         C_CTL:   n = CYC_CTL;
         C_BTEST: n = CYC_BT;
         default: n = CYC_STD;
      endcase
      return n - 3'd1;
   endfunction

   data_space u_data_space (
      .clk     (clk),
      .rd_en   (dm_re),
      .rd_addr (dm_ra),
      .wr_en   (dm_we),
      .wr_addr (dm_wa),
      .wr_data (dm_wd),
      .rd_data (dm_rd)
   );

   // -----------------------------------------------------------------
   // Datapath terms
   // -----------------------------------------------------------------
   always_comb begin
      cls        = (core_reg.cnt == 3'd1) ? decode(prog_data) : decode(core_reg.op);
      opd        = (cls == C_ALU_IMM) ? core_reg.b1 : dm_rd;
      sum9       = {1'b0, core_reg.acc} + {1'b0, opd};
      diff9      = {1'b0, core_reg.acc} - {1'b0, opd};
      tested_bit = dm_rd[core_reg.op[2:0]];
      ext_target = {core_reg.op[3:0], core_reg.b1};
      unique case (prog_data[6:5])
         COND_C:  cond_true = core_reg.c;
         COND_NC: cond_true = !core_reg.c;
         COND_Z:  cond_true = core_reg.z;
         COND_NZ: cond_true = !core_reg.z;
      endcase
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_comb begin
      core_next      = core_reg;
      core_next.wd1  = wd_hw_select;
      core_next.wd2  = core_reg.wd1;
      core_next.halt = 1'b0;
      core_next.idle = 1'b0;
      core_next.done = 1'b0;
      core_next.cnt  = core_reg.cnt + 3'd1;
      dm_re = 1'b0;
      dm_ra = 8'h00;
      dm_we = 1'b0;
      dm_wa = core_reg.b1;
      dm_wd = 8'h00;
      res   = 8'h00;
      un_opd = 8'h00;
      nxt   = core_reg.pc + 12'h001;
      if (int_entry) begin
         core_next.sz = core_reg.z;
         core_next.sc = core_reg.c;
      end
      unique case (core_reg.cnt)
         // Address runs one byte ahead of the one-cycle program memory
         3'd0: core_next.pa = core_reg.pc + 12'h001;
         3'd1: begin
            core_next.op = prog_data;
            core_next.pa = core_reg.pc + 12'h002;
            if (cls == C_REL && cond_true) begin
               nxt = prog_data[4] ? core_reg.pc - {8'h00, prog_data[3:0]}
                                  : core_reg.pc + {8'h00, prog_data[3:0]};
            end
            // Undecoded opcodes outside the control row must stay a no-operation
            if (cls == C_CTL && prog_data[7:4] == 4'hD) begin
               unique case (prog_data[2:0])
                  CTL_RET, CTL_RETURN_FROM_INTERRUPT: begin
                     core_next.sp = core_reg.sp - 3'd1;
                     nxt = core_reg.stk[core_reg.sp - 3'd1];
                     if (prog_data[2:0] == CTL_RETURN_FROM_INTERRUPT) begin
                        core_next.z = core_reg.sz;
                        core_next.c = core_reg.sc;
                     end
                  end
                  CTL_HALT: begin
                     core_next.halt = !core_reg.wd2;
                     core_next.idle = core_reg.wd2;
                  end
                  CTL_IDLE: core_next.idle = 1'b1;
                  default: ;
               endcase
            end
         end
         3'd2: begin
            core_next.b1 = prog_data;
            dm_re        = 1'b1;
            dm_ra        = prog_data;
            if (cls == C_ALU_IND || cls == C_UN_IND) begin
               dm_ra        = core_reg.xr[core_reg.op[4]];
               core_next.b1 = core_reg.xr[core_reg.op[4]];
            end
            if (cls == C_SH_INC || cls == C_SH_DEC) begin
               core_next.b1 = SHORT_BASE | {6'h00, core_reg.op[1:0]};
            end
         end
         3'd3: begin
            core_next.b2 = prog_data;
            unique case (cls)
               C_ALU_IND, C_ALU_DIR, C_ALU_IMM: begin
                  unique case (core_reg.op[1:0])
                     ALU_ADD: {core_next.c, res} = sum9;
                     ALU_AND: begin
                        res         = core_reg.acc & opd;
                        core_next.c = 1'b0;
                     end
                     ALU_CMP: {core_next.c, res} = diff9;
                     ALU_SUB: {core_next.c, res} = diff9;
                  endcase
                  core_next.z = (res == 8'h00);
                  if (core_reg.op[1:0] != ALU_CMP) core_next.acc = res;
               end
               C_UN_IND, C_UN_DIR, C_SH_INC, C_SH_DEC: begin
                  un_opd = (cls == C_SH_INC || cls == C_SH_DEC) ? core_reg.xr[core_reg.op[1:0]] : dm_rd;
                  if (cls == C_SH_INC || (cls != C_SH_DEC && core_reg.op[1:0] == UN_INC)) res = un_opd + 8'h01;
                  else if (cls == C_SH_DEC || core_reg.op[1:0] == UN_DEC) res = un_opd - 8'h01;
                  if (!(cls == C_UN_IND || cls == C_UN_DIR) || core_reg.op[1:0] != UN_CLR) begin
                     core_next.z = (res == 8'h00);
                  end
                  dm_we = 1'b1;
                  dm_wd = res;
               end
               C_ACC: begin
                  unique case (core_reg.op[1:0])
                     ACC_COM: res = ~core_reg.acc;
                     ACC_RLC: res = {core_reg.acc[6:0], core_reg.c};
                     default: res = {core_reg.acc[6:0], 1'b0};
                  endcase
                  core_next.c   = (core_reg.op[1:0] == ACC_COM) ? res[7] : core_reg.acc[7];
                  core_next.z   = (res == 8'h00);
                  core_next.acc = res;
               end
               C_BSET: begin
                  dm_we = 1'b1;
                  dm_wd = core_reg.op[3] ? (dm_rd | (8'h01 << core_reg.op[2:0]))
                                         : (dm_rd & ~(8'h01 << core_reg.op[2:0]));
               end
               C_JUMP: nxt = ext_target;
               C_CALL: begin
                  nxt = ext_target;
                  core_next.stk[core_reg.sp] = core_reg.pc + 12'h002;
                  core_next.sp = core_reg.sp + 3'd1;
               end
               default: ;
            endcase
            // Two-byte instructions skip their operand byte
            if (!(cls inside {C_ACC, C_ALU_IND, C_UN_IND, C_SH_INC, C_SH_DEC, C_BTEST, C_JUMP, C_CALL})) begin
               nxt = core_reg.pc + 12'h002;
            end
         end
         3'd4: begin
            core_next.c = tested_bit;
            nxt = core_reg.pc + 12'h003;
            if (tested_bit == core_reg.op[3]) begin
               nxt = core_reg.pc + 12'h002 + {{4{core_reg.b2[7]}}, core_reg.b2};
            end
         end
         default: ;
      endcase
      if (dm_we && dm_wa[7:2] == SHORT_BASE[7:2]) begin
         core_next.xr[dm_wa[1:0]] = dm_wd;
      end
      if (core_reg.cnt != 3'd0 && core_reg.cnt == last_cycle(cls)) begin
         core_next.cnt  = 3'd0;
         core_next.pc   = nxt;
         core_next.pa   = nxt;
         core_next.done = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         core_reg     <= '0;
         core_reg.pc  <= PC_RESET;
         core_reg.pa  <= PC_RESET;
         core_reg.acc <= ACC_RESET;
      end else begin
         core_reg <= core_next;
      end
   end

   assign prog_addr  = core_reg.pa;
   assign acc_out    = core_reg.acc;
   assign zero_flag  = core_reg.z;
   assign carry_flag = core_reg.c;
   assign halt_req   = core_reg.halt;
   assign idle_req   = core_reg.idle;
   assign instr_done = core_reg.done;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence bt_start;
      core_reg.cnt == 3'd1 && decode(prog_data) == C_BTEST;
   endsequence
   sequence bt_end;
      core_reg.cnt == 3'd0 && core_reg.done;
   endsequence

   rel_two_cycle_a: assert property (core_reg.cnt == 3'd1 && decode(prog_data) == C_REL
      |=> core_reg.cnt == 3'd0 && core_reg.done && $stable(core_reg.z) && $stable(core_reg.c))
      else $error("relative jump length or flags wrong");
   rel_not_taken_a: assert property (core_reg.cnt == 3'd1 && decode(prog_data) == C_REL && !cond_true
      |=> core_reg.pc == $past(core_reg.pc) + 12'h001)
      else $error("untaken branch did not fall through");
   btest_len_a: assert property (bt_start |-> ##4 bt_end)
      else $error("bit test not five cycles");
   btest_carry_a: assert property (core_reg.cnt == 3'd4
      |=> core_reg.c == $past(tested_bit) && core_reg.z == $past(core_reg.z))
      else $error("tested bit not copied to carry");
   bitop_flags_a: assert property (core_reg.cnt == 3'd3 && cls == C_BSET
      |=> $stable(core_reg.c) && $stable(core_reg.z) && core_reg.done)
      else $error("bit set/clear changed flags");
   incdec_carry_a: assert property (core_reg.cnt == 3'd3 && (cls == C_SH_INC || cls == C_SH_DEC)
      |=> $stable(core_reg.c))
      else $error("increment or decrement changed carry");
   halt_watchdog_a: assert property (core_reg.cnt == 3'd1 && prog_data[7:4] == 4'hD
      && decode(prog_data) == C_CTL && prog_data[2:0] == CTL_HALT && core_reg.wd2 |=> idle_req && !halt_req)
      else $error("halt not replaced by idle");
   halt_plain_a: assert property (core_reg.cnt == 3'd1 && prog_data[7:4] == 4'hD
      && decode(prog_data) == C_CTL && prog_data[2:0] == CTL_HALT && !core_reg.wd2 |=> halt_req && !idle_req)
      else $error("halt without watchdog not requested");
   jump_target_a: assert property (core_reg.cnt == 3'd3 && cls == C_JUMP
      |=> core_reg.pc == $past(ext_target) && prog_addr == core_reg.pc)
      else $error("jump target wrong");
   add_carry_a: assert property (core_reg.cnt == 3'd3 && cls == C_ALU_DIR && core_reg.op[1:0] == ALU_ADD
      |=> core_reg.c == $past(sum9[8]) && core_reg.z == (core_reg.acc == 8'h00))
      else $error("add flags wrong");
endmodule

// [dv/prog_rom.sv]
// Program memory model with one cycle of read latency
`timescale 1ns/1ns
module prog_rom (
   input  wire logic        clk,
   input  wire logic [11:0] prog_addr,
   output logic      [7:0]  prog_data
);
   logic [7:0] mem [0:4095];

   // -----------------------------------------------------------------
   // Loading
   // -----------------------------------------------------------------
   // Unused space holds a changing pattern so a runaway fetch shows up
   task automatic fill();
      for (int a = 0; a < 4096; a++) begin
         mem[a] = 8'hA5 ^ a[7:0];
      end
   endtask

   task automatic put(input logic [11:0] a, input logic [7:0] b [$]);
      foreach (b[k]) begin
         mem[a + k[11:0]] = b[k];
      end
   endtask

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      prog_data <= mem[prog_addr];
   end
endmodule

// [dv/tb.sv]
// Self-checking testbench for the execute and decode block
`timescale 1ns/1ns
module tb;
   logic        clk;
   logic        reset;
   logic        wd_hw_select;
   logic        int_entry;
   logic [7:0]  prog_data;
   logic [11:0] prog_addr;
   logic [7:0]  acc_out;
   logic        zero_flag;
   logic        carry_flag;
   logic        halt_req;
   logic        idle_req;
   logic        instr_done;
   int          failures;
   int          comparisons;

   exec_core i_dut (
      .clk          (clk),
      .reset        (reset),
      .prog_data    (prog_data),
      .wd_hw_select (wd_hw_select),
      .int_entry    (int_entry),
      .prog_addr    (prog_addr),
      .acc_out      (acc_out),
      .zero_flag    (zero_flag),
      .carry_flag   (carry_flag),
      .halt_req     (halt_req),
      .idle_req     (idle_req),
      .instr_done   (instr_done)
   );

   prog_rom i_rom (
      .clk       (clk),
      .prog_addr (prog_addr),
      .prog_data (prog_data)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic give_verdict();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic do_reset(input logic wd);
      i_rom.fill();
      reset        = 1'b1;
      wd_hw_select = wd;
      int_entry    = 1'b0;
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
   endtask

   // Waits for the next instruction boundary; cyc of 0 skips the length check
   task automatic step(input logic [11:0] pc, input logic [7:0] a, input logic z, input logic c,
                       input int cyc, input logic h, input logic i);
      int   n;
      logic hs;
      logic is;
      n  = 0;
      hs = 1'b0;
      is = 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
         hs = hs | halt_req;
         is = is | idle_req;
      end while (instr_done !== 1'b1 && n < 40);
      if (n >= 40) begin
         failures++;
         give_verdict();
      end else begin
         check("prog_addr", prog_addr, pc);
         check("acc_out", {4'h0, acc_out}, {4'h0, a});
         check("zero_flag", {11'h0, zero_flag}, {11'h0, z});
         check("carry_flag", {11'h0, carry_flag}, {11'h0, c});
         check("halt_req", {11'h0, hs}, {11'h0, h});
         check("idle_req", {11'h0, is}, {11'h0, i});
         if (cyc != 0) check("cycles", n[11:0], cyc[11:0]);
      end
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic run_alu();
      do_reset(1'b0);
      i_rom.put(12'h000, '{8'hD8, 8'hC8, 8'hF0, 8'hC8, 8'h10, 8'hCB, 8'h01, 8'hCA, 8'hFF,
                          8'hC9, 8'h0F, 8'hD4, 8'hD5, 8'hD6, 8'hD6, 8'hD6, 8'hD6});
      step(12'h001, 8'h00, 0, 0, 2, 0, 0);
      step(12'h003, 8'hF0, 0, 0, 4, 0, 0);
      step(12'h005, 8'h00, 1, 1, 4, 0, 0);
      step(12'h007, 8'hFF, 0, 1, 4, 0, 0);
      step(12'h009, 8'hFF, 1, 0, 4, 0, 0);
      step(12'h00B, 8'h0F, 0, 0, 4, 0, 0);
      step(12'h00C, 8'hF0, 0, 1, 4, 0, 0);
      step(12'h00D, 8'hE1, 0, 1, 4, 0, 0);
      step(12'h00E, 8'hC2, 0, 1, 4, 0, 0);
      step(12'h00F, 8'h84, 0, 1, 4, 0, 0);
      step(12'h010, 8'h08, 0, 1, 4, 0, 0);
      step(12'h011, 8'h10, 0, 0, 4, 0, 0);
   endtask

   // Bit operations only ever touch plain memory bytes here
   task automatic run_data();
      do_reset(1'b0);
      i_rom.put(12'h000, '{8'hC8, 8'h01, 8'hC8, 8'hFF, 8'hE6, 8'h40, 8'hE5, 8'h40, 8'hE4, 8'h40,
                          8'hE4, 8'h40, 8'hC4, 8'h40, 8'hE6, 8'h80, 8'hE8, 8'hE6, 8'h01, 8'hB9,
                          8'h01, 8'hC0, 8'hE6, 8'h81, 8'hE6, 8'h00, 8'hB8, 8'h00, 8'hD0, 8'hB1,
                          8'h01, 8'hC4, 8'h01, 8'hEC, 8'hE6, 8'h83, 8'hEB, 8'hC4, 8'h83,
                          8'hF0, 8'hC4, 8'h00});
      step(12'h002, 8'h01, 0, 0, 4, 0, 0);
      step(12'h004, 8'h00, 1, 1, 4, 0, 0);
      step(12'h006, 8'h00, 1, 1, 4, 0, 0);
      step(12'h008, 8'h00, 0, 1, 4, 0, 0);
      step(12'h00A, 8'h00, 1, 1, 4, 0, 0);
      step(12'h00C, 8'h00, 0, 1, 4, 0, 0);
      step(12'h00E, 8'h01, 0, 0, 4, 0, 0);
      step(12'h010, 8'h01, 0, 0, 4, 0, 0);
      step(12'h011, 8'h01, 0, 0, 4, 0, 0);
      step(12'h013, 8'h01, 0, 0, 4, 0, 0);
      step(12'h015, 8'h01, 0, 0, 4, 0, 0);
      step(12'h016, 8'h03, 0, 0, 4, 0, 0);
      step(12'h018, 8'h03, 0, 0, 4, 0, 0);
      step(12'h01A, 8'h03, 0, 0, 4, 0, 0);
      step(12'h01C, 8'h03, 0, 0, 4, 0, 0);
      step(12'h01D, 8'h04, 0, 0, 4, 0, 0);
      step(12'h01F, 8'h04, 0, 0, 4, 0, 0);
      step(12'h021, 8'h04, 0, 0, 4, 0, 0);
      step(12'h022, 8'h04, 1, 0, 4, 0, 0);
      step(12'h024, 8'h04, 1, 0, 4, 0, 0);
      step(12'h025, 8'h04, 0, 0, 4, 0, 0);
      step(12'h027, 8'h05, 0, 0, 4, 0, 0);
      step(12'h028, 8'h05, 0, 0, 4, 0, 0);
      step(12'h02A, 8'h07, 0, 0, 4, 0, 0);
   endtask

   task automatic run_branch();
      do_reset(1'b0);
      i_rom.put(12'h000, '{8'hE6, 8'h20, 8'hBB, 8'h20, 8'hD8, 8'h25});
      i_rom.put(12'h00A, '{8'h03, 8'hC8, 8'h00, 8'h64, 8'h44});
      i_rom.put(12'h012, '{8'hAB, 8'h20, 8'h10, 8'h81, 8'hC0});
      i_rom.put(12'h019, '{8'h01, 8'h35});
      i_rom.put(12'h024, '{8'hA3, 8'h20, 8'h05, 8'hA2, 8'h20, 8'hF0});
      i_rom.put(12'h1C0, '{8'h92, 8'hA0, 8'h62, 8'h00, 8'hC8, 8'hFF, 8'h03});
      i_rom.put(12'h2A0, '{8'hC8, 8'h01, 8'hD9});
      step(12'h002, 8'h00, 0, 0, 4, 0, 0);
      step(12'h004, 8'h00, 0, 0, 4, 0, 0);
      step(12'h005, 8'h00, 0, 0, 2, 0, 0);
      step(12'h00A, 8'h00, 0, 0, 2, 0, 0);
      step(12'h00B, 8'h00, 0, 0, 2, 0, 0);
      step(12'h00D, 8'h00, 1, 0, 4, 0, 0);
      step(12'h00E, 8'h00, 1, 0, 2, 0, 0);
      step(12'h012, 8'h00, 1, 0, 2, 0, 0);
      step(12'h024, 8'h00, 1, 1, 5, 0, 0);
      step(12'h027, 8'h00, 1, 1, 5, 0, 0);
      step(12'h019, 8'h00, 1, 0, 5, 0, 0);
      step(12'h01A, 8'h00, 1, 0, 2, 0, 0);
      step(12'h015, 8'h00, 1, 0, 2, 0, 0);
      step(12'h1C0, 8'h00, 1, 0, 4, 0, 0);
      step(12'h2A0, 8'h00, 1, 0, 4, 0, 0);
      step(12'h2A2, 8'h01, 0, 0, 4, 0, 0);
      step(12'h1C2, 8'h01, 0, 0, 2, 0, 0);
      step(12'h1C4, 8'h01, 0, 0, 2, 0, 0);
      step(12'h1C6, 8'h00, 1, 1, 4, 0, 0);
      step(12'h1C9, 8'h00, 1, 1, 2, 0, 0);
   endtask

   task automatic run_control(input logic wd);
      do_reset(wd);
      i_rom.put(12'h000, '{8'hC8, 8'h00, 8'h91, 8'h00, 8'hDB, 8'hDC, 8'hDD});
      i_rom.put(12'h100, '{8'hC8, 8'h01, 8'hDA});
      step(12'h002, 8'h00, 1, 0, 4, 0, 0);
      int_entry = 1'b1;
      @(posedge clk);
      #1 int_entry = 1'b0;
      step(12'h100, 8'h00, 1, 0, 0, 0, 0);
      step(12'h102, 8'h01, 0, 0, 4, 0, 0);
      step(12'h004, 8'h01, 1, 0, 2, 0, 0);
      step(12'h005, 8'h01, 1, 0, 2, !wd, wd);
      step(12'h006, 8'h01, 1, 0, 2, 0, 1);
      step(12'h007, 8'h01, 1, 0, 2, 0, 0);
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      failures     = 0;
      comparisons  = 0;
      reset        = 1'b1;
      wd_hw_select = 1'b0;
      int_entry    = 1'b0;
      run_alu();
      run_data();
      run_branch();
      run_control(1'b0);
      run_control(1'b1);
      give_verdict();
   end
endmodule
